/* verilog/reference_input_qualifier.sv */
// Purpose: Qualify reference and oscillator inputs for the DPLL selector
// Assumes: ppm errors and window detector flags come from same-clock logic
// Notes: Osc detector level arrives from an analog block and is synchronised
`timescale 1ns/1ns

module reference_input_qualifier
  import refq_pkg::*;
#(
  parameter int N = NUM_REFS,
  parameter int TICK_CYC = VT_TICK_CYC
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic osc_in_range_i,
  input wire logic [N*16-1:0] ppm_err_i,
  input wire logic [N*3-1:0] win_flags_i,
  input wire logic dpll_locked_i,
  input wire logic in_gap_i,
  output logic osc_freq_loss_flag_o,
  output logic osc_valid_o,
  output logic [N-1:0] ref_qualified_o,
  output logic [N*4-1:0] status_pins_o,
  output logic hitless_ok_o
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [N-1:0][31:0] cfg;
    logic [N-1:0][31:0] thr;
    logic [N-1:0][31:0] vt;
    logic [31:0] rdata;
    logic wait_n;
    logic [2:0] osc_sync;
    logic osc_loss;
    logic osc_valid;
    logic [19:0] tick_cnt;
    logic [N-1:0][15:0] vt_cnt;
    logic [N-1:0] qual;
    logic [N*4-1:0] pins;
    logic hitless;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;
  logic [N-1:0] fdet_flag;
  logic [N-1:0] any_flag;
  logic [1:0] sel;
  logic tick;

  // Strip the config, threshold and timer words into the per-input settings record
  function automatic ref_cfg_type unpack_cfg(input logic [31:0] c, input logic [31:0] t,
                                             input logic [31:0] v);
    ref_cfg_type r;
    r.fdet_en = c[CFG_FDET_EN_BIT];
    r.miss_en = c[CFG_MISS_EN_BIT];
    r.runt_en = c[CFG_RUNT_EN_BIT];
    r.pv_en = c[CFG_PV_EN_BIT];
    r.vt_en = c[CFG_VT_EN_BIT];
    r.avg = c[CFG_AVG_LSB +: 4];
    r.acc = c[CFG_ACC_LSB +: 4];
    r.thr_valid = t[15:0];
    r.thr_invalid = t[31:16];
    r.vt_len = v[15:0];
    return r;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction

  // Threshold clamp: more averaging lowers the programmable ceiling
  function automatic logic [15:0] clamp_thr(input logic [15:0] t, input logic [3:0] avg);
    logic [15:0] m;
    m = THR_MAX_BASE >> avg;
    return (t > m) ? m : t;
  endfunction

  assign sel = s_q.ctrl[CTRL_SEL_LSB +: 2];
  assign tick = (s_q.tick_cnt == 20'(TICK_CYC - 1));

  // One frequency monitor per reference input
  for (genvar g = 0; g < N; g++)
  begin : g_fm
    ref_cfg_type rc;
    ext_flags_type ef;
    assign rc = unpack_cfg(s_q.cfg[g], s_q.thr[g], s_q.vt[g]);
    assign ef = win_flags_i[g*3 +: 3];
    freq_monitor u_fm (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .en_i(rc.fdet_en),
      .ppm_err_i(ppm_err_i[g*16 +: 16]),
      .thr_valid_i(clamp_thr(rc.thr_valid, rc.avg)),
      .thr_invalid_i(clamp_thr(rc.thr_invalid, rc.avg)),
      .avg_i(rc.avg),
      .acc_i(rc.acc),
      .flag_o(fdet_flag[g])
    );
    // Disabled monitors are masked out before qualification
    assign any_flag[g] = fdet_flag[g] | (rc.miss_en & ef.miss)
                       | (rc.runt_en & ef.runt) | (rc.pv_en & ef.pv);
  end

  // Register file, monitors and qualification
  always_comb
  begin
    ref_cfg_type rc;
    ext_flags_type ef;
    logic [7:0] a;
    rc = '0;
    ef = '0;
    a = avs_address_i;
    s_d = s_q;
    // Two-cycle access: waitrequest high on the first cycle of a request
    s_d.wait_n = (avs_read_i | avs_write_i) & ~s_q.wait_n;
    if ((avs_read_i | avs_write_i) & ~s_q.wait_n)
    begin
      s_d.rdata = RD_UNMAPPED;
      if (a == OFS_CTRL)
      begin
        s_d.rdata = s_q.ctrl;
        if (avs_write_i)
          s_d.ctrl = merge(s_q.ctrl, avs_writedata_i, avs_byteenable_i);
      end
      else if (a == OFS_STATUS)
      begin
        // Selected input only, so software sees what the DPLL tracks
        s_d.rdata = {24'h000000, s_q.hitless, s_q.osc_valid, s_q.osc_loss,
                     s_q.qual[sel], s_q.pins[sel*4 +: 4]};
      end
      for (int i = 0; i < N; i++)
      begin
        if (a == OFS_REF_CFG0 + 8'(i*4))
        begin
          s_d.rdata = s_q.cfg[i];
          if (avs_write_i)
            s_d.cfg[i] = merge(s_q.cfg[i], avs_writedata_i, avs_byteenable_i);
        end
        if (a == OFS_REF_THR0 + 8'(i*4))
        begin
          s_d.rdata = s_q.thr[i];
          if (avs_write_i)
            s_d.thr[i] = merge(s_q.thr[i], avs_writedata_i, avs_byteenable_i);
        end
        if (a == OFS_REF_VT0 + 8'(i*4))
        begin
          s_d.rdata = s_q.vt[i];
          if (avs_write_i)
            s_d.vt[i] = merge(s_q.vt[i], avs_writedata_i, avs_byteenable_i);
        end
        if (a == OFS_REF_ERR0 + 8'(i*4))
          s_d.rdata = {16'h0000, ppm_err_i[i*16 +: 16]};
      end
    end
    // Three-stage sync; decision taken only when stages two and three agree
    s_d.osc_sync = {s_q.osc_sync[1:0], osc_in_range_i};
    if (s_q.osc_sync[1] == s_q.osc_sync[2])
      s_d.osc_loss = ~s_q.osc_sync[2];
    // Bypass steers validity only; loss flag keeps the raw detector result
    s_d.osc_valid = s_q.ctrl[CTRL_BYPASS_BIT] | ~s_d.osc_loss;
    s_d.tick_cnt = tick ? 20'h00000 : s_q.tick_cnt + 20'h00001;
    for (int i = 0; i < N; i++)
    begin
      rc = unpack_cfg(s_q.cfg[i], s_q.thr[i], s_q.vt[i]);
      ef = win_flags_i[i*3 +: 3];
      // Pins show every input, selected or not
      s_d.pins[i*4 +: 4] = {fdet_flag[i], rc.miss_en & ef.miss,
                            rc.runt_en & ef.runt, rc.pv_en & ef.pv};
      if (any_flag[i])
      begin
        s_d.qual[i] = 1'b0;
        s_d.vt_cnt[i] = 16'h0000;
      end
      else if (!rc.vt_en)
        s_d.qual[i] = 1'b1;
      else if (s_q.vt_cnt[i] >= rc.vt_len)
        s_d.qual[i] = 1'b1;
      else if (tick)
        s_d.vt_cnt[i] = s_q.vt_cnt[i] + 16'h0001;
    end
    // Hitless allowed only once locked, no zero-delay sync, no gap
    s_d.hitless = dpll_locked_i & ~s_q.ctrl[CTRL_ZDS_BIT] & ~in_gap_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RST;
      for (int i = 0; i < N; i++)
      begin
        s_q.cfg[i] <= CFG_RST;
        s_q.thr[i] <= THR_RST;
        s_q.vt[i] <= VT_RST;
      end
      s_q.osc_loss <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = ~s_q.wait_n;
  assign osc_freq_loss_flag_o = s_q.osc_loss;
  assign osc_valid_o = s_q.osc_valid;
  assign ref_qualified_o = s_q.qual;
  assign status_pins_o = s_q.pins;
  assign hitless_ok_o = s_q.hitless;
endmodule

/* verilog/refq_pkg.sv */
// Purpose: Shared constants and types for the reference input qualifier
// Assumes: 10 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes: Four reference inputs; register map is word aligned
package refq_pkg;
  localparam int NUM_REFS = 4;
  localparam int CLK_HZ = 10000000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_REF_CFG0 = 8'h10;
  localparam logic [7:0] OFS_REF_THR0 = 8'h20;
  localparam logic [7:0] OFS_REF_VT0 = 8'h30;
  localparam logic [7:0] OFS_REF_ERR0 = 8'h40;
  // Control field positions
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_ZDS_BIT = 1;
  localparam int CTRL_SEL_LSB = 4;
  // Ref config field positions
  localparam int CFG_FDET_EN_BIT = 0;
  localparam int CFG_MISS_EN_BIT = 1;
  localparam int CFG_RUNT_EN_BIT = 2;
  localparam int CFG_PV_EN_BIT = 3;
  localparam int CFG_VT_EN_BIT = 4;
  localparam int CFG_AVG_LSB = 8;
  localparam int CFG_ACC_LSB = 12;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST = 32'h0064_0032;
  localparam logic [31:0] VT_RST = 32'h0000_000a;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // Timing: validation timer tick is 1 ms
  localparam int VT_TICK_US = 1000;
  localparam int VT_TICK_CYC = (CLK_HZ / 1000000) * VT_TICK_US;
  // Base measurement window in cycles before accuracy and averaging scaling
  localparam int MEAS_BASE_CYC = 16;
  // Largest programmable threshold at averaging factor zero
  localparam logic [15:0] THR_MAX_BASE = 16'hffff;

  typedef struct packed {
    logic fdet_en;
    logic miss_en;
    logic runt_en;
    logic pv_en;
    logic vt_en;
    logic [3:0] avg;
    logic [3:0] acc;
    logic [15:0] thr_valid;
    logic [15:0] thr_invalid;
    logic [15:0] vt_len;
  } ref_cfg_type;

  typedef struct packed {
    logic miss;
    logic runt;
    logic pv;
  } ext_flags_type;
endpackage

/* verilog/freq_monitor.sv */
// Purpose: Per-reference ppm frequency monitor with hysteresis
// Assumes: ppm error is supplied by the counter front end each cycle
// Notes: Larger averaging or finer accuracy lengthens the window
`timescale 1ns/1ns
module freq_monitor
  import refq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic [15:0] ppm_err_i,
  input wire logic [15:0] thr_valid_i,
  input wire logic [15:0] thr_invalid_i,
  input wire logic [3:0] avg_i,
  input wire logic [3:0] acc_i,
  output logic flag_o
);
  typedef struct packed {
    logic flag;
    logic [23:0] cnt;
    logic [19:0] pk;
  } fm_state_type;

  fm_state_type s_q;
  fm_state_type s_d;
  logic [23:0] win;
  logic [19:0] pk_now;

  // Window length: base scaled by averaging and accuracy setting
  always_comb
  begin
    win = 24'(MEAS_BASE_CYC) << avg_i;
    win = win + (24'(MEAS_BASE_CYC) * 24'(acc_i));
  end

  // Worst error in a window decides the flag at its end
  always_comb
  begin
    s_d = s_q;
    // Peak including this cycle's sample, so the last sample of a window counts
    pk_now = (20'(ppm_err_i) > s_q.pk) ? 20'(ppm_err_i) : s_q.pk;
    if (!en_i)
    begin
      s_d.flag = 1'b0;
      s_d.cnt = 24'h000000;
      s_d.pk = 20'h00000;
    end
    else
    begin
      s_d.pk = pk_now;
      s_d.cnt = s_q.cnt + 24'h000001;
      if (s_q.cnt >= win)
      begin
        s_d.cnt = 24'h000000;
        s_d.pk = 20'h00000;
        // Judge the finished window before the peak is cleared for the next
        if (pk_now < 20'(thr_valid_i))
          s_d.flag = 1'b0;
        else if (pk_now > 20'(thr_invalid_i))
          s_d.flag = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign flag_o = s_q.flag;
endmodule

/* bench/refq_chk.sv */
// ----------------------------------------
// Purpose: Port level checks of the reference input qualifier
// Assumes: One clock domain, synchronous active low reset
// Notes: Bound to every instance of the top module
// ----------------------------------------
`timescale 1ns/1ns
module refq_chk
  import refq_pkg::*;
#(
  parameter int N = NUM_REFS,
  parameter int TICK_CYC = VT_TICK_CYC
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic osc_in_range_i,
  input wire logic [N*16-1:0] ppm_err_i,
  input wire logic [N*3-1:0] win_flags_i,
  input wire logic dpll_locked_i,
  input wire logic in_gap_i,
  input wire logic osc_freq_loss_flag_o,
  input wire logic osc_valid_o,
  input wire logic [N-1:0] ref_qualified_o,
  input wire logic [N*4-1:0] status_pins_o,
  input wire logic hitless_ok_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // Bus answer timing: one wait cycle, then a single ready cycle
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  AST_WAIT_ANS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
    !avs_waitrequest_o) else $error("request not answered next cycle");
  AST_IDLE: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("waitrequest low without a request");

  // Oscillator detector; synchroniser needs up to four cycles
  AST_LOSS_CLR: assert property (osc_in_range_i [*7] |-> !osc_freq_loss_flag_o)
    else $error("osc loss flag stuck while in range");
  AST_LOSS_SET: assert property (!osc_in_range_i [*7] |-> osc_freq_loss_flag_o)
    else $error("osc loss flag clear while out of range");
  AST_VALID: assert property ((!osc_freq_loss_flag_o) [*2] |-> osc_valid_o)
    else $error("osc not valid with loss flag clear");

  // Reset state holds even while reset is asserted
  AST_RST: assert property (disable iff (1'b0) !rst_b_i |=> avs_waitrequest_o &&
    osc_freq_loss_flag_o && ref_qualified_o == '0 && status_pins_o == '0)
    else $error("bad state after reset");

  // Per input: a flag removes qualification; quiet window inputs give quiet window pins
  for (genvar i = 0; i < N; i++)
  begin : g_ref
    AST_FLAG_DROP: assert property ((|status_pins_o[i*4+:4]) [*2] |->
      !ref_qualified_o[i]) else $error("qualified while flagged");
    AST_WIN_MASK: assert property ((win_flags_i[i*3+:3] == 3'h0) [*3] |->
      status_pins_o[i*4+:3] == 3'h0) else $error("window pin without cause");
  end
endmodule

bind reference_input_qualifier refq_chk #(.N(N), .TICK_CYC(TICK_CYC)) u_chk (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .osc_in_range_i(osc_in_range_i),
  .ppm_err_i(ppm_err_i), .win_flags_i(win_flags_i), .dpll_locked_i(dpll_locked_i),
  .in_gap_i(in_gap_i), .osc_freq_loss_flag_o(osc_freq_loss_flag_o),
  .osc_valid_o(osc_valid_o), .ref_qualified_o(ref_qualified_o),
  .status_pins_o(status_pins_o), .hitless_ok_o(hitless_ok_o));

/* bench/tb_top.sv */
// ----------------------------------------
// Purpose: Self-checking bench of the reference input qualifier
// Assumes: Validation tick shortened to 4 cycles
// Notes: Bus answers are taken at the rising edge; other outputs at the falling edge
// ----------------------------------------
`timescale 1ns/1ns
module tb_top;
  import refq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic osc = 1'b0;
  logic [63:0] ppm = 64'h0;
  logic [11:0] win = 12'h000;
  logic lck = 1'b0;
  logic gap = 1'b0;
  logic [31:0] rdat;
  logic wrq;
  logic loss;
  logic oval;
  logic [3:0] qual;
  logic [15:0] pins;
  logic hok;
  logic [31:0] q;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  reference_input_qualifier #(.N(4), .TICK_CYC(4)) uut (
    .mclk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .osc_in_range_i(osc),
    .ppm_err_i(ppm), .win_flags_i(win), .dpll_locked_i(lck), .in_gap_i(gap),
    .osc_freq_loss_flag_o(loss), .osc_valid_o(oval), .ref_qualified_o(qual),
    .status_pins_o(pins), .hitless_ok_o(hok));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // One access; request held until the rising edge that sees waitrequest low,
  // read data taken at that edge, released only after it
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int t;
    begin
      t = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      be <= b;
      rd <= !w;
      wr <= w;
      @(posedge clk);
      while (wrq !== 1'b0 && t < 50)
      begin
        @(posedge clk);
        t++;
      end
      if (t == 50)
        n_errors++;
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0, 4'hf);
      chk(nm, q, e);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    settle(2);
    chk("loss", {31'h0, loss}, 32'h1);
    rdc("ctrl", OFS_CTRL, CTRL_RST);
    rdc("cfg0", OFS_REF_CFG0, CFG_RST);
    rdc("thr0", OFS_REF_THR0, THR_RST);
    rdc("vt0", OFS_REF_VT0, VT_RST);
    bus(1'b1, 8'h80, 32'hffff_ffff, 4'hf);
    rdc("unmapped", 8'h80, RD_UNMAPPED);
    bus(1'b1, OFS_STATUS, 32'hffff_ffff, 4'hf);
    rdc("status", OFS_STATUS, 32'h30);
    bus(1'b1, OFS_REF_THR0 + 8'h04, 32'h1234_5678, 4'h1);
    rdc("thr1", OFS_REF_THR0 + 8'h04, 32'h0064_0078);
    // Oscillator in range, out of range, then bypassed
    @(posedge clk);
    osc <= 1'b1;
    settle(8);
    chk("oval", {31'h0, oval}, 32'h1);
    @(posedge clk);
    osc <= 1'b0;
    settle(8);
    chk("oval", {31'h0, oval}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h1, 4'hf);
    settle(8);
    chk("oval", {31'h0, oval}, 32'h1);
    rdc("status", OFS_STATUS, 32'h70);
    bus(1'b1, OFS_CTRL, 32'h0, 4'hf);
    // All window flags up; of input 1 only the missing pulse monitor enabled
    @(posedge clk);
    win <= 12'hfff;
    bus(1'b1, OFS_REF_CFG0 + 8'h04, 32'h2, 4'hf);
    // Input 0 carries a 1PPS reference: phase-valid monitor only
    bus(1'b1, OFS_REF_CFG0, 32'h8, 4'hf);
    settle(4);
    chk("pins", {16'h0, pins}, 32'h0041);
    chk("qual", {28'h0, qual}, 32'hc);
    rdc("status", OFS_STATUS, 32'h21);
    bus(1'b1, OFS_CTRL, 32'h10, 4'hf);
    rdc("status", OFS_STATUS, 32'h24);
    @(posedge clk);
    win <= 12'h000;
    // Frequency monitor on input 2 with default 50/100 thresholds
    bus(1'b1, OFS_REF_CFG0 + 8'h08, 32'h1, 4'hf);
    @(posedge clk);
    ppm[47:32] <= 16'h00c8;
    settle(60);
    chk("pins", {16'h0, pins}, 32'h0800);
    rdc("err2", OFS_REF_ERR0 + 8'h08, 32'h0000_00c8);
    @(posedge clk);
    ppm[47:32] <= 16'h004b;
    settle(60);
    chk("pins", {16'h0, pins}, 32'h0800);
    @(posedge clk);
    ppm[47:32] <= 16'h000a;
    settle(60);
    chk("pins", {16'h0, pins}, 32'h0000);
    // Top thresholds: averaging of 3 clamps them to 0x1fff, below the error;
    // accuracy step 1 stretches the window to 145 cycles
    bus(1'b1, OFS_REF_THR0 + 8'h08, 32'hffff_ffff, 4'hf);
    @(posedge clk);
    ppm[47:32] <= 16'h4000;
    settle(60);
    chk("pins", {16'h0, pins}, 32'h0000);
    bus(1'b1, OFS_REF_CFG0 + 8'h08, 32'h1301, 4'hf);
    settle(300);
    chk("pins", {16'h0, pins}, 32'h0800);
    bus(1'b1, OFS_REF_CFG0 + 8'h08, 32'h0, 4'hf);
    settle(4);
    chk("pins", {16'h0, pins}, 32'h0000);
    // Validation timer of 3 ticks on input 3
    bus(1'b1, OFS_REF_VT0 + 8'h0c, 32'h3, 4'hf);
    @(posedge clk);
    win <= 12'h800;
    bus(1'b1, OFS_REF_CFG0 + 8'h0c, 32'h12, 4'hf);
    settle(4);
    chk("qual3", {31'h0, qual[3]}, 32'h0);
    @(posedge clk);
    win <= 12'h000;
    settle(6);
    chk("qual3", {31'h0, qual[3]}, 32'h0);
    settle(14);
    chk("qual3", {31'h0, qual[3]}, 32'h1);
    @(posedge clk);
    win <= 12'h800;
    @(posedge clk);
    win <= 12'h000;
    settle(3);
    chk("qual3", {31'h0, qual[3]}, 32'h0);
    settle(20);
    // Hitless permit: locked, unlocked, in a gap, zero-delay sync on
    @(posedge clk);
    osc <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, OFS_CTRL, (k == 3) ? 32'h32 : 32'h30, 4'hf);
      lck <= (k != 1);
      gap <= (k == 2);
      settle(6);
      chk("hitless", {31'h0, hok}, (k == 0) ? 32'h1 : 32'h0);
    end
    report_and_stop;
  end
endmodule
